// File: design/pmr_params.svh
// Purpose: Offsets, field positions, reset values and frame counts of the management registers.
// Assumes: Included by the frame engine, the register top and the bench.
// Notes: Definitions only.
//
// What this block does
// - Control register bits 4:0 hold a writable MMD device select, reset to zero.
// - Mode 00 makes the window the register address inside the selected device.
// - Non-zero modes make the window carry data of the addressed register; resets zero.
// - Mode 01 no increment, 10 increment on reads and writes, 11 on writes only.
// - Extended status bits 15 and 14 are read-only zero.
// - Extended status bits 13 and 12 are read-only one.
// - Loopback register bit 8 enables remote loopback; read/write, reset zero.
// - Writing one to cable test bit 15 starts the test; it self-clears when done.
// - Writing zero to cable test bit 15 stops the test; resets to zero.
// - Cable test bit 15 reads one while the test runs.
// - Bit 15 reading zero after a start means valid results; read them only then. A stop by a zero write also reads zero and keeps the old results.
// - Result field codes: 00 normal, 01 open, 10 short, 11 reserved.
`ifndef PMR_PARAMS_SVH
`define PMR_PARAMS_SVH

`define PMR_OFS_MMD_CTRL 5'h0d
`define PMR_OFS_MMD_WIN 5'h0e
`define PMR_OFS_EXT_STAT 5'h0f
`define PMR_OFS_RLB 5'h11
`define PMR_OFS_CBL 5'h12

`define PMR_CTRL_MODE_HI 15
`define PMR_CTRL_MODE_LO 14
`define PMR_CTRL_DEV_HI 4
`define PMR_RLB_EN_BIT 8
`define PMR_CBL_EN_BIT 15
`define PMR_CBL_RSV_BIT 14

`define PMR_CTRL_RESET 16'h0000
`define PMR_WIN_RESET 16'h0000
`define PMR_EXT_STAT_VAL 16'h3000
`define PMR_RLB_RESET 16'h00f4

`define PMR_PRE_LEN 6'h20
`define PMR_HDR_LAST 5'h0c
`define PMR_DAT_LAST 5'h0f

`endif

// File: design/pmr_pkg.sv
// Purpose: Types shared by the management register block.
// Assumes: Nothing beyond the language.
// Notes: Encodings of the MMD access modes and the state machines.
package pmr_pkg;

  typedef enum logic [1:0] {
    PMR_MODE_REG = 2'h0,
    PMR_MODE_DATA = 2'h1,
    PMR_MODE_INC_RW = 2'h2,
    PMR_MODE_INC_W = 2'h3
  } pmr_mode_e;

  typedef enum logic [1:0] {
    PMR_CBL_NORMAL = 2'h0,
    PMR_CBL_OPEN = 2'h1,
    PMR_CBL_SHORT = 2'h2,
    PMR_CBL_RSVD = 2'h3
  } pmr_cbl_res_e;

  typedef enum logic [3:0] {
    PMR_FR_PRE = 4'h1,
    PMR_FR_HDR = 4'h2,
    PMR_FR_TA = 4'h4,
    PMR_FR_DAT = 4'h8
  } pmr_frame_e;

  typedef enum logic [1:0] {
    PMR_CT_IDLE = 2'h1,
    PMR_CT_RUN = 2'h2
  } pmr_ctest_e;

endpackage

// File: design/pmr_reg_if.sv
// Purpose: Register access path from the serial frame engine to the register bank.
// Assumes: One clock; rd and wr are one-cycle pulses.
// Notes: rdata answers combinationally for the address on regad.
`timescale 1ns/1ns
`default_nettype none
interface pmr_reg_if;
  logic wr;
  logic rd;
  logic [4:0] regad;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport engine (output wr, output rd, output regad, output wdata, input rdata);
  modport bank (input wr, input rd, input regad, input wdata, output rdata);
endinterface
`default_nettype wire

// File: design/pmr_mmd_store.sv
// Purpose: Flip-flop storage behind the MMD data window.
// Assumes: Index built from the device select and register address.
// Notes: Sixteen words; read is combinational.
`timescale 1ns/1ns
`default_nettype none
module pmr_mmd_store
  import pmr_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Access
  input wire logic [3:0] i_idx,
  input wire logic i_we,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata
);
  typedef struct packed {
    logic [15:0][15:0] mem;
  } pmr_store_s;

  pmr_store_s s_q;
  pmr_store_s s_d;

  always_comb
  begin
    s_d = s_q;
    if (i_we)
    begin
      s_d.mem[i_idx] = i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.mem[i_idx];
endmodule
`default_nettype wire

// File: design/pmr_frame_engine.sv
// Purpose: Serial management frame slave: decodes frames and drives read data.
// Assumes: MDC and MDIO inputs are synchronous to the reference clock.
// Notes: Acts on rising MDC edges only; 32-bit preamble required.
`timescale 1ns/1ns
`default_nettype none
`include "pmr_params.svh"
module pmr_frame_engine
  import pmr_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Serial pins
  input wire logic i_mdc,
  input wire logic i_mdio_i,
  output logic o_mdio_o,
  output logic o_mdio_oe,
  input wire logic [4:0] i_phy_addr,
  // Register access
  pmr_reg_if.engine reg_port
);
  typedef struct packed {
    pmr_frame_e st;
    logic [5:0] ones;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic mdc_q;
    logic is_rd;
    logic mdio_o;
    logic mdio_oe;
    logic wr;
    logic rd;
    logic [4:0] regad;
    logic [15:0] wdata;
  } pmr_eng_s;

  pmr_eng_s s_q;
  pmr_eng_s s_d;
  logic rise;
  logic [12:0] hdr;

  assign rise = i_mdc & ~s_q.mdc_q;
  assign hdr = {s_q.sh[11:0], i_mdio_i};

  always_comb
  begin
    s_d = s_q;
    s_d.mdc_q = i_mdc;
    s_d.wr = 1'b0;
    s_d.rd = 1'b0;
    if (s_q.rd)
    begin
      s_d.sh = reg_port.rdata;
    end
    case (s_q.st)
      PMR_FR_PRE:
      begin
        if (rise)
        begin
          if (i_mdio_i)
          begin
            s_d.ones = (s_q.ones == `PMR_PRE_LEN) ? s_q.ones : s_q.ones + 6'h01;
          end
          else
          begin
            s_d.ones = 6'h00;
            if (s_q.ones == `PMR_PRE_LEN)
            begin
              s_d.st = PMR_FR_HDR;
              s_d.cnt = 5'h00;
            end
          end
        end
      end
      PMR_FR_HDR:
      begin
        if (rise)
        begin
          s_d.sh = {s_q.sh[14:0], i_mdio_i};
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == `PMR_HDR_LAST)
          begin
            s_d.cnt = 5'h00;
            if (hdr[12] && hdr[9:5] == i_phy_addr && (hdr[11:10] == 2'h2 || hdr[11:10] == 2'h1))
            begin
              s_d.st = PMR_FR_TA;
              s_d.regad = hdr[4:0];
              s_d.is_rd = (hdr[11:10] == 2'h2);
              s_d.rd = (hdr[11:10] == 2'h2);
            end
            else
            begin
              s_d.st = PMR_FR_PRE;
            end
          end
        end
      end
      PMR_FR_TA:
      begin
        if (rise)
        begin
          if (s_q.cnt == 5'h00)
          begin
            s_d.cnt = 5'h01;
            s_d.mdio_oe = s_q.is_rd;
            s_d.mdio_o = 1'b0;
          end
          else
          begin
            s_d.st = PMR_FR_DAT;
            s_d.cnt = 5'h00;
            if (s_q.is_rd)
            begin
              s_d.mdio_o = s_q.sh[15];
              s_d.sh = {s_q.sh[14:0], 1'b0};
            end
          end
        end
      end
      PMR_FR_DAT:
      begin
        if (rise)
        begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.is_rd)
          begin
            s_d.mdio_o = s_q.sh[15];
            s_d.sh = {s_q.sh[14:0], 1'b0};
          end
          else
          begin
            s_d.sh = {s_q.sh[14:0], i_mdio_i};
          end
          if (s_q.cnt == `PMR_DAT_LAST)
          begin
            s_d.st = PMR_FR_PRE;
            s_d.mdio_oe = 1'b0;
            s_d.mdio_o = 1'b0;
            s_d.wr = ~s_q.is_rd;
            s_d.wdata = {s_q.sh[14:0], i_mdio_i};
          end
        end
      end
      default:
      begin
        s_d.st = PMR_FR_PRE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s_q <= '{st: PMR_FR_PRE, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_mdio_o = s_q.mdio_o;
  assign o_mdio_oe = s_q.mdio_oe;
  assign reg_port.wr = s_q.wr;
  assign reg_port.rd = s_q.rd;
  assign reg_port.regad = s_q.regad;
  assign reg_port.wdata = s_q.wdata;
endmodule
`default_nettype wire

// File: design/pmr_regs_top.sv
// Purpose: Management register subset: MMD indirect access, extended status, loopback, cable test.
// Assumes: Registers reached over the serial management pins; analog test engine outside.
// Notes: Unmapped registers read zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
`include "pmr_params.svh"
module pmr_regs_top
  import pmr_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Management serial pins
  input wire logic i_mdc,
  input wire logic i_mdio_i,
  output logic o_mdio_o,
  output logic o_mdio_oe,
  input wire logic [4:0] i_phy_addr,
  // Remote loopback
  output logic o_remote_loopback,
  // Cable test engine
  output logic o_cbl_run,
  output logic [1:0] o_cbl_pair,
  input wire logic i_cbl_done,
  input wire logic [1:0] i_cbl_status,
  input wire logic [7:0] i_cbl_fault
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] addr;
    logic [15:0] rlb;
    pmr_ctest_e cst;
    logic rsv14;
    logic [1:0] pair;
    logic [1:0] rsv11;
    pmr_cbl_res_e status;
    logic [7:0] fault;
  } pmr_top_s;

  pmr_top_s s_q;
  pmr_top_s s_d;
  pmr_reg_if reg_bus ();
  pmr_mode_e mode;
  logic [15:0] store_rdata;
  logic store_we;
  logic win_wr;
  logic win_rd;
  logic cbl_wr;
  logic data_mode;

  // ************************************************************
  // Submodules
  // ************************************************************
  pmr_frame_engine u_engine (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_mdc(i_mdc),
    .i_mdio_i(i_mdio_i),
    .o_mdio_o(o_mdio_o),
    .o_mdio_oe(o_mdio_oe),
    .i_phy_addr(i_phy_addr),
    .reg_port(reg_bus.engine)
  );

  pmr_mmd_store u_store (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_idx({s_q.ctrl[1:0], s_q.addr[1:0]}),
    .i_we(store_we),
    .i_wdata(reg_bus.wdata),
    .o_rdata(store_rdata)
  );

  // ************************************************************
  // Read mux
  // ************************************************************
  function automatic logic [15:0] pmr_read(input logic [4:0] ad, input pmr_top_s s,
                                           input logic [15:0] sd);
    logic [15:0] v;
    v = 16'h0000;
    case (ad)
      `PMR_OFS_MMD_CTRL: v = s.ctrl;
      `PMR_OFS_MMD_WIN: v = (s.ctrl[15:14] == PMR_MODE_REG) ? s.addr : sd;
      `PMR_OFS_EXT_STAT: v = `PMR_EXT_STAT_VAL;
      `PMR_OFS_RLB: v = s.rlb;
      `PMR_OFS_CBL: v = {s.cst == PMR_CT_RUN, s.rsv14, s.pair, s.rsv11, s.status, s.fault};
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  assign mode = pmr_mode_e'(s_q.ctrl[`PMR_CTRL_MODE_HI:`PMR_CTRL_MODE_LO]);
  assign data_mode = (mode != PMR_MODE_REG);
  assign win_wr = reg_bus.wr && reg_bus.regad == `PMR_OFS_MMD_WIN;
  assign win_rd = reg_bus.rd && reg_bus.regad == `PMR_OFS_MMD_WIN;
  assign cbl_wr = reg_bus.wr && reg_bus.regad == `PMR_OFS_CBL;
  assign store_we = win_wr && data_mode;
  assign reg_bus.rdata = pmr_read(reg_bus.regad, s_q, store_rdata);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    s_d = s_q;
    if (reg_bus.wr && reg_bus.regad == `PMR_OFS_MMD_CTRL)
    begin
      s_d.ctrl = reg_bus.wdata;
    end
    if (win_wr && !data_mode)
    begin
      s_d.addr = reg_bus.wdata;
    end
    if ((win_wr && (mode == PMR_MODE_INC_RW || mode == PMR_MODE_INC_W)) ||
        (win_rd && mode == PMR_MODE_INC_RW))
    begin
      s_d.addr = s_q.addr + 16'h0001;
    end
    if (reg_bus.wr && reg_bus.regad == `PMR_OFS_RLB)
    begin
      s_d.rlb = {reg_bus.wdata[15:1], 1'b0};
    end
    if (s_q.cst == PMR_CT_RUN && i_cbl_done)
    begin
      s_d.cst = PMR_CT_IDLE;
      s_d.status = pmr_cbl_res_e'(i_cbl_status);
      s_d.fault = i_cbl_fault;
    end
    if (cbl_wr)
    begin
      s_d.rsv14 = reg_bus.wdata[`PMR_CBL_RSV_BIT];
      s_d.pair = reg_bus.wdata[13:12];
      s_d.rsv11 = reg_bus.wdata[11:10];
      if (reg_bus.wdata[`PMR_CBL_EN_BIT])
      begin
        s_d.cst = PMR_CT_RUN;
      end
      else if (s_q.cst == PMR_CT_RUN)
      begin
        s_d.cst = PMR_CT_IDLE;
      end
    end
    case (s_d.cst)
      PMR_CT_IDLE: s_d.cst = PMR_CT_IDLE;
      PMR_CT_RUN: s_d.cst = PMR_CT_RUN;
      default: s_d.cst = PMR_CT_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s_q <= '{ctrl: `PMR_CTRL_RESET, addr: `PMR_WIN_RESET, rlb: `PMR_RLB_RESET,
               cst: PMR_CT_IDLE, status: PMR_CBL_NORMAL, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_remote_loopback = s_q.rlb[`PMR_RLB_EN_BIT];
  assign o_cbl_run = s_q.cst[1];
  assign o_cbl_pair = s_q.pair;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_dev_write;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (reg_bus.wr && reg_bus.regad == `PMR_OFS_MMD_CTRL) |=>
      s_q.ctrl[`PMR_CTRL_DEV_HI:0] == $past(reg_bus.wdata[4:0]);
  endproperty
  a_dev_write: assert property (p_dev_write) else $error("device select not written");

  property p_addr_write;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (win_wr && mode == PMR_MODE_REG) |=> s_q.addr == $past(reg_bus.wdata) && !$past(store_we);
  endproperty
  a_addr_write: assert property (p_addr_write) else $error("register address not taken");

  property p_data_read;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (win_wr && mode == PMR_MODE_DATA) |=> reg_bus.rdata == $past(reg_bus.wdata);
  endproperty
  a_data_read: assert property (p_data_read) else $error("window data mismatch");

  property p_post_inc;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    ((win_wr && mode != PMR_MODE_REG) || win_rd) |=>
      s_q.addr == $past(s_q.addr) + (($past(mode) == PMR_MODE_INC_RW ||
      ($past(mode) == PMR_MODE_INC_W && $past(win_wr))) ? 16'h0001 : 16'h0000);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post increment wrong");

  property p_ext_stat;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    reg_bus.regad == `PMR_OFS_EXT_STAT |-> reg_bus.rdata[15:12] == 4'h3;
  endproperty
  a_ext_stat: assert property (p_ext_stat) else $error("extended status wrong");

  property p_loopback;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (reg_bus.wr && reg_bus.regad == `PMR_OFS_RLB) |=>
      o_remote_loopback == $past(reg_bus.wdata[8]) && s_q.rlb[0] == 1'b0;
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback enable wrong");

  property p_self_clear;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (o_cbl_run && i_cbl_done && !cbl_wr) |=> !o_cbl_run && s_q.fault == $past(i_cbl_fault);
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("test did not self clear");

  property p_disable;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (cbl_wr && !reg_bus.wdata[15]) |=> !o_cbl_run;
  endproperty
  a_disable: assert property (p_disable) else $error("test not disabled");

  property p_run_read;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (o_cbl_run && reg_bus.regad == `PMR_OFS_CBL) |-> reg_bus.rdata[15];
  endproperty
  a_run_read: assert property (p_run_read) else $error("busy bit not shown");

  property p_result;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (o_cbl_run ##1 !o_cbl_run && !$past(cbl_wr)) |-> s_q.status == $past(i_cbl_status);
  endproperty
  a_result: assert property (p_result) else $error("result not captured");

  // No register may move unless its own access or the test engine moves it.
  property p_ctrl_hold;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    !(reg_bus.wr && reg_bus.regad == `PMR_OFS_MMD_CTRL) |=> $stable(s_q.ctrl);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control moved unasked");

  property p_rd_addr;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (win_rd && mode == PMR_MODE_REG) |-> reg_bus.rdata == s_q.addr;
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("window address not read");

  property p_addr_hold;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    !(win_wr || win_rd) |=> $stable(s_q.addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved unasked");

  property p_no_inc;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (win_rd && (mode == PMR_MODE_DATA || mode == PMR_MODE_INC_W)) |=> $stable(s_q.addr);
  endproperty
  a_no_inc: assert property (p_no_inc) else $error("read moved address");

  property p_ext_wr;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (reg_bus.wr && reg_bus.regad == `PMR_OFS_EXT_STAT) |=>
      $stable({s_q.ctrl, s_q.addr, s_q.rlb});
  endproperty
  a_ext_wr: assert property (p_ext_wr) else $error("status write took effect");

  property p_rlb_hold;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    !(reg_bus.wr && reg_bus.regad == `PMR_OFS_RLB) |=> $stable(o_remote_loopback);
  endproperty
  a_rlb_hold: assert property (p_rlb_hold) else $error("loopback moved unasked");

  property p_start;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (cbl_wr && reg_bus.wdata[`PMR_CBL_EN_BIT]) |=> o_cbl_run;
  endproperty
  a_start: assert property (p_start) else $error("test not started");

  property p_run_hold;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (o_cbl_run && !i_cbl_done && !cbl_wr) |=> o_cbl_run;
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("test ended early");

  property p_idle_hold;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (!o_cbl_run && !(cbl_wr && reg_bus.wdata[`PMR_CBL_EN_BIT])) |=> !o_cbl_run;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("test started unasked");

  property p_res_hold;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    !(o_cbl_run && i_cbl_done) |=> $stable({s_q.status, s_q.fault});
  endproperty
  a_res_hold: assert property (p_res_hold) else $error("result moved unasked");

  property p_res_take;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (o_cbl_run && i_cbl_done) |=>
      s_q.status == $past(i_cbl_status) && s_q.fault == $past(i_cbl_fault);
  endproperty
  a_res_take: assert property (p_res_take) else $error("result code not taken");

  property p_done_bit;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (!o_cbl_run && reg_bus.regad == `PMR_OFS_CBL) |-> !reg_bus.rdata[15];
  endproperty
  a_done_bit: assert property (p_done_bit) else $error("idle test reads busy");
endmodule
`default_nettype wire

// File: bench/pmr_station.sv
// Purpose: Management station model that drives MDC and MDIO frames.
// Assumes: The MDIO wire is resolved outside, with a pull-up.
// Notes: MDC half period is three reference clocks; MDC rests low between frames.
`timescale 1ns/1ns
`default_nettype none
module pmr_station (
  // Clock
  input wire logic i_ref_clk,
  // Serial pins
  input wire logic i_mdio,
  output logic o_mdc,
  output logic o_mdio,
  output logic o_mdio_oe
);
  initial
  begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_mdio_oe = 1'b0;
  end

  task automatic wait_ref(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  // Drives or releases one bit and samples the wire just before the rise.
  task automatic bit_cycle(input logic drv, input logic b, output logic smp);
    o_mdio_oe = drv;
    o_mdio = b;
    wait_ref(3);
    smp = i_mdio;
    o_mdc = 1'b1;
    wait_ref(3);
    o_mdc = 1'b0;
  endtask

  // The last sixteen samples of a read frame are the data bits.
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] wd, input int pre, output logic [15:0] rd);
    logic [13:0] hdr;
    logic [17:0] tail;
    logic s;
    hdr = {2'b01, op, phy, ra};
    tail = {2'b10, wd};
    for (int i = 0; i < pre; i++) bit_cycle(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
    for (int i = 17; i >= 0; i--)
    begin
      bit_cycle(op != 2'b10, tail[i], s);
      rd = {rd[14:0], s};
    end
    o_mdio_oe = 1'b0;
    wait_ref(4);
  endtask
endmodule
`default_nettype wire

// File: bench/phy_mmd_loopback_cable_test_regs_bench.sv
// Purpose: Self-checking bench for the management register block.
// Assumes: The station model sends frames; the bench plays the cable test engine.
// Notes: The MDIO wire has a pull-up when nobody drives it.
`timescale 1ns/1ns
`default_nettype none
`include "pmr_params.svh"
module phy_mmd_loopback_cable_test_regs_bench
  import pmr_pkg::*;
;
  localparam logic [4:0] phy = 5'h01;
  localparam logic [4:0] r_ct = `PMR_OFS_MMD_CTRL;
  localparam logic [4:0] r_win = `PMR_OFS_MMD_WIN;
  localparam logic [4:0] r_ext = `PMR_OFS_EXT_STAT;
  localparam logic [4:0] r_rlb = `PMR_OFS_RLB;
  localparam logic [4:0] r_cbl = `PMR_OFS_CBL;
  logic i_ref_clk, i_nrst, mdc, st_o, st_oe, dut_o, dut_oe, mdio_w, lb, run, done;
  logic [1:0] pair, cst, ps, sc;
  logic [7:0] cf, pf, f;
  logic [15:0] x;
  int error_cnt = 0;
  int n_compared = 0;

  assign mdio_w = dut_oe ? dut_o : (st_oe ? st_o : 1'b1);

  pmr_station st (.i_ref_clk(i_ref_clk), .i_mdio(mdio_w), .o_mdc(mdc), .o_mdio(st_o),
                  .o_mdio_oe(st_oe));
  pmr_regs_top DUT (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_mdc(mdc), .i_mdio_i(mdio_w),
                    .o_mdio_o(dut_o), .o_mdio_oe(dut_oe), .i_phy_addr(phy),
                    .o_remote_loopback(lb), .o_cbl_run(run), .o_cbl_pair(pair),
                    .i_cbl_done(done), .i_cbl_status(cst), .i_cbl_fault(cf));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  // ************************************************************
  // Access and compare tasks.
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    st.xfer(2'b01, phy, a, d, 32, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] q;
    st.xfer(2'b10, phy, a, 16'h0000, 32, q);
    chk(q, exp);
  endtask

  task automatic test_done(input logic [1:0] s, input logic [7:0] fd);
    cst = s;
    cf = fd;
    done = 1'b1;
    tick(1);
    done = 1'b0;
    tick(2);
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge i_ref_clk);
    error_cnt++;
    complete_run();
  end

  // ************************************************************
  // Test sequence.
  // ************************************************************
  initial
  begin
    i_nrst = 1'b0;
    done = 1'b0;
    cst = 2'b00;
    cf = 8'h00;
    ps = 2'b00;
    pf = 8'h00;
    tick(2);
    i_nrst = 1'b1;
    tick(2);
    rd(r_ct, 16'h0000);
    rd(r_win, 16'h0000);
    rd(r_ext, 16'h3000);
    rd(r_rlb, 16'h00f4);
    rd(r_cbl, 16'h0000);
    wr(r_ext, 16'hc000);
    rd(r_ext, 16'h3000);
    wr(5'h05, 16'hffff);
    rd(5'h05, 16'h0000);
    // Loopback is set, read back and cleared by whole-register writes.
    wr(r_rlb, 16'h01f4);
    chk({15'h0, lb}, 16'h0001);
    rd(r_rlb, 16'h01f4);
    wr(r_rlb, 16'h00f4);
    chk({15'h0, lb}, 16'h0000);
    // Wrong address, bad opcode and short preamble are all ignored.
    st.xfer(2'b01, 5'h02, r_rlb, 16'h01f4, 32, x);
    st.xfer(2'b00, phy, r_rlb, 16'h01f4, 32, x);
    st.xfer(2'b01, phy, r_rlb, 16'h01f4, 31, x);
    rd(r_rlb, 16'h00f4);
    // MMD window in each operation mode.
    wr(r_ct, 16'h0001);
    rd(r_ct, 16'h0001);
    wr(r_win, 16'h0002);
    rd(r_win, 16'h0002);
    wr(r_ct, 16'h4001);
    wr(r_win, 16'habcd);
    rd(r_win, 16'habcd);
    rd(r_win, 16'habcd);
    wr(r_ct, 16'h8001);
    rd(r_win, 16'habcd);
    wr(r_win, 16'h1111);
    wr(r_ct, 16'h0001);
    rd(r_win, 16'h0004);
    wr(r_ct, 16'hc001);
    wr(r_win, 16'h2222);
    wr(r_win, 16'h3333);
    wr(r_ct, 16'h0001);
    rd(r_win, 16'h0006);
    wr(r_win, 16'h0005);
    wr(r_ct, 16'hc001);
    rd(r_win, 16'h3333);
    rd(r_win, 16'h3333);
    wr(r_ct, 16'h0001);
    rd(r_win, 16'h0005);
    wr(r_win, 16'h0003);
    wr(r_ct, 16'h4001);
    rd(r_win, 16'h1111);
    wr(r_ct, 16'h4002);
    rd(r_win, 16'h0000);
    // Cable test with every result code; results are read once the bit reads zero.
    for (int s = 0; s < 4; s++)
    begin
      sc = s[1:0];
      f = 8'(8'h11 * s + 8'h03);
      wr(r_cbl, {2'b10, sc, 12'h000});
      chk({15'h0, run}, 16'h0001);
      chk({14'h0, pair}, {14'h0, sc});
      rd(r_cbl, {2'b10, sc, 2'b00, ps, pf});
      test_done(sc, f);
      chk({15'h0, run}, 16'h0000);
      rd(r_cbl, {2'b00, sc, 2'b00, sc, f});
      ps = sc;
      pf = f;
    end
    wr(r_cbl, 16'h9000);
    wr(r_cbl, 16'h1000);
    chk({15'h0, run}, 16'h0000);
    test_done(2'b01, 8'h5a);
    rd(r_cbl, {4'h1, 2'b00, ps, pf});
    // A second reset with loopback set restores the reset values.
    wr(r_rlb, 16'h01f4);
    i_nrst = 1'b0;
    tick(2);
    i_nrst = 1'b1;
    tick(2);
    chk({15'h0, lb}, 16'h0000);
    rd(r_rlb, 16'h00f4);
    rd(r_ct, 16'h0000);
    rd(r_win, 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
